// *** rtl/clock_wait_halt_control.sv ***
// clock, wait-state, halt and wait-for-interrupt control
// assumes hclk is the oscillator and cpu-side inputs share hclk
`timescale 1ns/100ps
`default_nettype none
module clock_wait_halt_control (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clock_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic [1:0]       hresp,
    output logic             oscillator_output,
    output logic             internal_clock_en,
    output logic             core_clock_en,
    input  wire logic        cycle_external,
    input  wire logic        cycle_program,
    input  wire logic        ext_wait_pin_n,
    input  wire logic        ext_wait_enable,
    input  wire logic        halt_req,
    input  wire logic        wfi_req,
    input  wire logic        irq_ack,
    input  wire logic [2:0]  core_priority_level,
    input  wire logic        dma_req,
    input  wire logic [2:0]  dma_priority,
    input  wire logic        dma_to_memory,
    output logic             dma_active,
    output logic             dma_done,
    input  wire logic [7:0]  cpu_ad_out,
    input  wire logic        cpu_ad_oe,
    input  wire logic [7:0]  cpu_high_addr,
    input  wire logic [7:0]  next_opcode_addr,
    input  wire logic        cpu_as_n,
    input  wire logic        cpu_ds_n,
    input  wire logic        cpu_rw_n,
    output logic [7:0]       muxed_addr_data_port_out,
    output logic             muxed_addr_data_port_oe,
    output logic [7:0]       high_address_port,
    output logic             address_strobe_n,
    output logic             data_strobe_n,
    output logic             read_write_n,
    output logic             halt_loop
);
    import clk_ctrl_pkg::*;
    // dma length, idle adds its overhead
    function automatic logic [DMA_W-1:0] dma_len(input logic mem,
                                                  input logic idle);
        logic [DMA_W-1:0] len;
        len = mem ? DMA_MEM_TICKS : DMA_REG_TICKS;
        if (idle) begin
            len = len + DMA_IDLE_EXTRA;
        end
        return len;
    endfunction : dma_len
    pwr_state_t       state;
    logic [7:0]       wait_ctrl;
    logic [7:0]       mode_cfg;
    logic             div_phase;
    logic             bypass_act;
    logic             mode_written;
    logic [CNT_W-1:0] base_left;
    logic [CNT_W-1:0] wait_left;
    logic             cyc_ext;
    logic [DMA_W-1:0] dma_left;
    logic             ack_pend;
    logic             extw_meta;
    logic             extw_sync_n;
    logic             dp_valid;
    logic             dp_write;
    logic [31:0]      dp_addr;
    logic             int_tick;
    logic             ext_hold;
    logic             cycle_end;
    logic             dma_ok_wfi;
    logic             dma_fin;
    logic             parked;
    logic             addr_phase;
    logic [CNT_W-1:0] presc_sel;
    logic [CNT_W-1:0] next_waits;
    // bus never stalls except while frozen by the clock enable
    assign hreadyout = clock_en;
    assign hresp     = HRESP_OKAY;
    assign presc_sel = mode_cfg[MODE_PRESC_LSB +: CNT_W];
    assign int_tick = clock_en && (state != ST_HALT)
                      && (bypass_act || div_phase);
    assign internal_clock_en = int_tick;
    assign ext_hold = ext_wait_enable && !extw_sync_n && cyc_ext;
    // core edge only once all counts spent
    assign cycle_end = int_tick && (state == ST_RUN)
                       && (base_left == '0) && (wait_left == '0)
                       && !ext_hold;
    assign dma_ok_wfi = dma_req && (dma_priority <= core_priority_level);
    assign dma_fin = int_tick && (dma_left == DMA_W'(1))
                     && ((state == ST_RUN_DMA) || (state == ST_WFI_DMA));
    // per-space wait count, internal gets none
    assign next_waits = !cycle_external ? '0 :
                        cycle_program ? wait_ctrl[WAIT_PROG_LSB +: CNT_W]
                                      : wait_ctrl[WAIT_DATA_LSB +: CNT_W];
    assign parked = (state == ST_WFI) || (state == ST_WFI_DMA)
                    || (state == ST_HALT);
    assign addr_phase = hsel && hready && htrans[1]
                        && (hsize == 3'h2 || hsize != 3'h2);
    // external wait pin synchroniser, first stage read only by second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            extw_meta   <= 1'b1;
            extw_sync_n <= 1'b1;
        end else if (clock_en) begin
            extw_meta   <= ext_wait_pin_n;
            extw_sync_n <= extw_meta;
        end
    end
    // oscillator divider; bypass changes only at a period end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_phase  <= 1'b0;
            bypass_act <= 1'b0;
        end else if (clock_en && state != ST_HALT) begin
            div_phase <= !div_phase;
            // bypass switch on boundary
            // reset value has the bypass bit set, so only a write may apply it
            if (div_phase) begin
                bypass_act <= mode_written && mode_cfg[MODE_BYPASS_BIT];
            end
        end
    end
    // stopped oscillator leaves its output high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oscillator_output <= 1'b0;
        end else if (clock_en) begin
            oscillator_output <= (state == ST_HALT) ? 1'b1
                                                     : !oscillator_output;
        end
    end
    // core cycle counters: prescale part first, then waits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_left <= '0;
            wait_left <= '0;
            cyc_ext   <= 1'b0;
        end else if (clock_en) begin
            if (cycle_end) begin
                // new rate taken at next cycle
                base_left <= presc_sel;
                wait_left <= next_waits;
                cyc_ext   <= cycle_external;
            end else if (state != ST_RUN) begin
                // n plus one ticks per cycle
                base_left <= presc_sel;
                wait_left <= '0;
                cyc_ext   <= 1'b0;
            end else if (int_tick) begin
                if (base_left != '0) begin
                    base_left <= base_left - CNT_W'(1);
                end else if (wait_left != '0) begin
                    wait_left <= wait_left - CNT_W'(1);
                end
            end
        end
    end
    // core clock enable from prescaled tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_clock_en <= 1'b0;
        end else if (clock_en) begin
            core_clock_en <= cycle_end;
        end
    end
    // power state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= ST_RUN;
            halt_loop <= 1'b0;
            ack_pend  <= 1'b0;
            dma_left  <= '0;
        end else if (clock_en) begin
            unique case (state)
                ST_RUN: begin
                    if (halt_req) begin
                        if (!wait_ctrl[WAIT_WDOG_OFF_BIT]) begin
                            halt_loop <= 1'b1;
                        end else begin
                            state <= ST_HALT;
                        end
                    end else if (wfi_req) begin
                        state    <= ST_WFI;
                        ack_pend <= 1'b0;
                    end else if (cycle_end && dma_req) begin
                        state    <= ST_RUN_DMA;
                        dma_left <= dma_len(dma_to_memory, 1'b0);
                    end
                end
                ST_RUN_DMA: begin
                    if (dma_fin) begin
                        state <= ST_RUN;
                    end
                    if (int_tick) begin
                        dma_left <= dma_left - DMA_W'(1);
                    end
                end
                ST_WFI: begin
                    if (irq_ack) begin
                        state <= ST_RUN;
                    end else if (int_tick && dma_ok_wfi) begin
                        state    <= ST_WFI_DMA;
                        dma_left <= dma_len(dma_to_memory, 1'b1);
                    end
                end
                ST_WFI_DMA: begin
                    // acknowledge during transfer is kept, not lost
                    if (irq_ack) begin
                        ack_pend <= 1'b1;
                    end
                    if (int_tick) begin
                        dma_left <= dma_left - DMA_W'(1);
                    end
                    if (dma_fin) begin
                        state    <= (ack_pend || irq_ack) ? ST_RUN : ST_WFI;
                        ack_pend <= 1'b0;
                    end
                end
                ST_HALT: state <= ST_HALT;
                default: state <= ST_RUN;
            endcase
        end
    end
    // dma status strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_active <= 1'b0;
            dma_done   <= 1'b0;
        end else if (clock_en) begin
            dma_active <= (state == ST_RUN_DMA) || (state == ST_WFI_DMA);
            dma_done   <= dma_fin;
        end
    end
    // interface lines parked while idle or halted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            muxed_addr_data_port_out <= '0;
            muxed_addr_data_port_oe  <= 1'b0;
            high_address_port        <= '0;
            address_strobe_n         <= 1'b1;
            data_strobe_n            <= 1'b1;
            read_write_n             <= 1'b1;
        end else if (clock_en) begin
            muxed_addr_data_port_out <= cpu_ad_out;
            muxed_addr_data_port_oe  <= cpu_ad_oe && !parked;
            high_address_port <= parked ? next_opcode_addr : cpu_high_addr;
            address_strobe_n  <= parked || cpu_as_n;
            data_strobe_n     <= parked || cpu_ds_n;
            read_write_n      <= parked || cpu_rw_n;
        end
    end
    // ahb address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end else if (clock_en) begin
            dp_valid <= addr_phase;
            dp_write <= addr_phase && hwrite;
            dp_addr  <= haddr;
        end
    end
    // register writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_ctrl    <= WAIT_CTRL_RESET;
            mode_cfg     <= MODE_CFG_RESET;
            mode_written <= 1'b0;
        end else if (clock_en && dp_valid && dp_write) begin
            if (dp_addr == OFS_WAIT_CTRL) begin
                wait_ctrl <= hwdata[7:0];
            end
            if (dp_addr == OFS_MODE_CFG) begin
                mode_cfg     <= hwdata[7:0];
                mode_written <= 1'b1;
            end
        end
    end
    // read data registered at the address phase; unmapped reads zero
    // a read right after a write to the same word returns the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (clock_en) begin
            hrdata <= '0;
            if (addr_phase && !hwrite) begin
                unique case (haddr)
                    OFS_WAIT_CTRL: hrdata <= {24'h000000, wait_ctrl};
                    OFS_MODE_CFG:  hrdata <= {24'h000000, mode_cfg};
                    OFS_STATUS: begin
                        hrdata <= {24'h000000, bypass_act, !extw_sync_n,
                                   halt_loop, state};
                    end
                    default: hrdata <= '0;
                endcase
            end
        end
    end
endmodule : clock_wait_halt_control
`default_nettype wire

// *** rtl/clk_ctrl_pkg.sv ***
// constants shared by the clock, wait and halt control block
// assumes a 32-bit AHB-Lite slave port, one register per aligned word
package clk_ctrl_pkg;
    // register byte addresses
    localparam logic [31:0] OFS_WAIT_CTRL = 32'h0000_00fc;
    localparam logic [31:0] OFS_MODE_CFG  = 32'h0000_00f8;
    localparam logic [31:0] OFS_STATUS    = 32'h0000_00f4;
    // reset values
    localparam logic [7:0] WAIT_CTRL_RESET = 8'h7f;
    localparam logic [7:0] MODE_CFG_RESET  = 8'he0;
    // wait control fields
    localparam int WAIT_DATA_LSB     = 0;
    localparam int WAIT_PROG_LSB     = 3;
    localparam int WAIT_WDOG_OFF_BIT = 6;
    // mode config fields
    localparam int MODE_PRESC_LSB  = 2;
    localparam int MODE_BYPASS_BIT = 5;
    // status fields (bits 4:0 carry the one-hot state)
    localparam int STAT_LOOP_BIT   = 5;
    localparam int STAT_EXTW_BIT   = 6;
    localparam int STAT_BYPASS_BIT = 7;
    // widths
    localparam int CNT_W = 3;
    localparam int DMA_W = 5;
    // dma transfer lengths in internal clock ticks
    localparam logic [4:0] DMA_REG_TICKS  = 5'h08;
    localparam logic [4:0] DMA_MEM_TICKS  = 5'h10;
    localparam logic [4:0] DMA_IDLE_EXTRA = 5'h02;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic [1:0] HRESP_OKAY        = 2'h0;
    // power states
    typedef enum logic [4:0] {
        ST_RUN     = 5'b00001,
        ST_RUN_DMA = 5'b00010,
        ST_WFI     = 5'b00100,
        ST_WFI_DMA = 5'b01000,
        ST_HALT    = 5'b10000
    } pwr_state_t;
endpackage : clk_ctrl_pkg

// *** tb/cwh_checker_assertions.sv ***
// port checker for the clock, wait and halt control block
// assumes a single hclk domain and a bind into the top module
`timescale 1ns/100ps
`default_nettype none
module cwh_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       clock_en,
    input wire logic       oscillator_output,
    input wire logic       internal_clock_en,
    input wire logic       core_clock_en,
    input wire logic       ext_wait_pin_n,
    input wire logic       ext_wait_enable,
    input wire logic       cycle_external,
    input wire logic       halt_req,
    input wire logic       wfi_req,
    input wire logic       irq_ack,
    input wire logic       dma_active,
    input wire logic       dma_done,
    input wire logic [7:0] next_opcode_addr,
    input wire logic       muxed_addr_data_port_oe,
    input wire logic [7:0] high_address_port,
    input wire logic       address_strobe_n,
    input wire logic       data_strobe_n,
    input wire logic       read_write_n,
    input wire logic       halt_loop
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // wfi taken while running; the dma guard avoids a request ignored mid-transfer
    sequence s_wfi;
        wfi_req && !halt_req && !dma_active && !dma_done && clock_en
            && oscillator_output != $past(oscillator_output);
    endsequence
    sequence s_calm;
        (clock_en && !irq_ack)[*2];
    endsequence
    property p_park;
        s_wfi ##1 s_calm |-> !muxed_addr_data_port_oe && address_strobe_n && data_strobe_n
            && read_write_n && high_address_port == $past(next_opcode_addr);
    endproperty
    a_park: assert property (p_park) else $error("bus lines not parked");
    property p_core_stop;
        s_wfi ##1 s_calm ##1 s_calm |->
            !core_clock_en && (internal_clock_en || $past(internal_clock_en));
    endproperty
    a_core_stop: assert property (p_core_stop) else $error("core clock in wfi");
    property p_osc_halt;
        clock_en && $past(clock_en) && $past(hresetn)
            && oscillator_output == $past(oscillator_output) |-> oscillator_output;
    endproperty
    a_osc_halt: assert property (p_osc_halt) else $error("oscillator stopped low");
    property p_loop_runs;
        halt_loop && clock_en && $past(clock_en) |-> oscillator_output != $past(oscillator_output);
    endproperty
    a_loop_runs: assert property (p_loop_runs) else $error("oscillator stopped");
    property p_core_tick;
        core_clock_en && $past(clock_en) |-> $past(internal_clock_en);
    endproperty
    a_core_tick: assert property (p_core_tick) else $error("core pulse off tick");
    property p_dma_len;
        $rose(dma_active) |-> !dma_done[*6];
    endproperty
    a_dma_len: assert property (p_dma_len) else $error("dma too short");
    property p_ext_hold;
        (ext_wait_enable && !ext_wait_pin_n && cycle_external && clock_en)[*8] |=> !core_clock_en;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("wait pin ignored");
    property p_div_reset;
        !$past(hresetn) |-> ##1 !(internal_clock_en && $past(internal_clock_en));
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("no divide after reset");
endmodule : cwh_checker
bind clock_wait_halt_control cwh_checker u_chk (.*);
`default_nettype wire

// *** tb/ext_mem_model.sv ***
// slow external memory holding the wait pin after each data strobe
// assumes the pin has a pull-up, so a released pin reads high
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
    input  wire logic       hclk,
    input  wire logic       data_strobe_n,
    input  wire logic [3:0] hold_ticks,
    output logic            ext_wait_pin_n
);
    logic       ds_q = 1'b1;
    logic [3:0] left = 4'h0;
    // slow device stalls; zero hold answers promptly
    always_ff @(posedge hclk) begin
        ds_q <= data_strobe_n;
        if (ds_q && !data_strobe_n)
            left <= hold_ticks;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign ext_wait_pin_n = (left == 4'h0); // pull-up once released
endmodule : ext_mem_model
`default_nettype wire

// *** tb/clock_wait_halt_control_tb_top.sv ***
// self-checking bench for the clock, wait and halt control block
// assumes the external memory model on the wait pin and a 50 MHz hclk
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module clock_wait_halt_control_tb_top;
    import clk_ctrl_pkg::*;
    logic hclk = 0, hresetn = 0, clock_en = 1, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0] htrans = 0, hresp;
    logic [2:0] hsize = 3'h2, core_priority_level = 0, dma_priority = 0;
    logic hreadyout, oscillator_output, internal_clock_en, core_clock_en, ext_wait_pin_n;
    logic cycle_external = 0, cycle_program = 0, ext_wait_enable = 0, halt_req = 0;
    logic wfi_req = 0, irq_ack = 0, dma_req = 0, dma_to_memory = 0, dma_active, dma_done;
    logic cpu_ad_oe = 0, cpu_as_n = 1, cpu_ds_n = 1, cpu_rw_n = 1, halt_loop;
    logic [7:0] cpu_ad_out = 0, cpu_high_addr = 0, next_opcode_addr = 0, high_address_port;
    logic [7:0] muxed_addr_data_port_out;
    logic muxed_addr_data_port_oe, address_strobe_n, data_strobe_n, read_write_n;
    logic [3:0] hold_ticks = 0;
    int fail_count = 0, total_checks = 0, cyc = 0, g, ci, cc, dr, dm, dw;
    assign hready = hreadyout;
    clock_wait_halt_control u_dut (.*);
    ext_mem_model u_mem (.hclk(hclk), .data_strobe_n(data_strobe_n),
        .hold_ticks(hold_ticks), .ext_wait_pin_n(ext_wait_pin_n));
    // clock, plus a cycle ceiling so a hang still ends in the report
    initial forever #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset
    // single transfer; each phase ends at the rising edge that sees hready
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ_BIT;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) begin
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) begin
            @(posedge hclk);
        end
        rv = hrdata;
    endtask : ahb
    // tick counts over n settled samples
    task automatic count(input int n);
        ci = 0;
        cc = 0;
        repeat (n) begin
            @(negedge hclk);
            ci += internal_clock_en;
            cc += core_clock_en;
        end
        @(posedge hclk);
    endtask : count
    // hclk distance between two core pulses, bounded
    task automatic gap;
        int k;
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while (!core_clock_en && k < 200);
        g = 0;
        do begin
            @(negedge hclk);
            g++;
        end while (!core_clock_en && g < 200);
        @(posedge hclk);
    endtask : gap
    task automatic two_gaps(input int e);
        gap();
        gap();
        `CHK(g, e)
    endtask : two_gaps
    // request a transfer, length from first active sample to done
    task automatic dma_len(input logic m, output int d);
        int k;
        dma_to_memory <= m;
        dma_req <= 1'b1;
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while (!dma_active && k < 100);
        @(posedge hclk);
        dma_req <= 1'b0;
        d = 0;
        do begin
            @(negedge hclk);
            d++;
        end while (!dma_done && d < 100);
        @(posedge hclk);
    endtask : dma_len
    task automatic t_regs;
        ahb(1'b0, OFS_WAIT_CTRL, 0);
        `CHK(rv, 32'h7f)
        ahb(1'b0, OFS_MODE_CFG, 0);
        `CHK(rv, 32'he0)
        ahb(1'b1, 32'h10, 32'hff);
        ahb(1'b0, 32'h10, 0);
        `CHK(rv, 32'h0)
        `CHK(hresp, HRESP_OKAY)
        ahb(1'b1, OFS_WAIT_CTRL, 32'h5d);
        ahb(1'b0, OFS_WAIT_CTRL, 0);
        `CHK(rv, 32'h5d)
        clock_en <= 1'b0;
        @(negedge hclk);
        `CHK(hreadyout, 1'b0)
        @(posedge hclk);
        clock_en <= 1'b1;
    endtask : t_regs
    task automatic t_clocks;
        ahb(1'b1, OFS_MODE_CFG, 32'hc0);
        count(4);
        count(20);
        `CHK(ci, 10)
        ahb(1'b1, OFS_MODE_CFG, 32'he0);
        count(4);
        count(20);
        `CHK(ci, 20)
        for (int n = 0; n < 8; n++) begin
            ahb(1'b1, OFS_MODE_CFG, 32'he0 | (n << 2));
            two_gaps(n + 1);
        end
        ahb(1'b1, OFS_MODE_CFG, 32'he0);
        two_gaps(1);
    endtask : t_clocks
    // program waits 3, data waits 5 from the register test
    task automatic t_waits;
        cycle_external <= 1'b1;
        cycle_program <= 1'b1;
        two_gaps(4);
        cycle_program <= 1'b0;
        two_gaps(6);
        ahb(1'b1, OFS_MODE_CFG, 32'hc0);
        two_gaps(12);
        cycle_external <= 1'b0;
        two_gaps(2);
        ahb(1'b1, OFS_MODE_CFG, 32'he0);
        cycle_external <= 1'b1;
        ext_wait_enable <= 1'b1;
        hold_ticks <= 4'hf;
        cpu_ds_n <= 1'b0;
        count(6);
        // status read while the model still holds the pin low
        ahb(1'b0, OFS_STATUS, 0);
        `CHK(rv[STAT_EXTW_BIT], 1'b1)
        count(10);
        `CHK(cc, 0)
        count(10);
        `CHK(cc > 0, 1'b1)
        cpu_ds_n <= 1'b1;
        ext_wait_enable <= 1'b0;
        cycle_external <= 1'b0;
    endtask : t_waits
    task automatic t_wfi;
        cpu_ad_oe <= 1'b1;
        cpu_ad_out <= 8'h3c;
        cpu_as_n <= 1'b0;
        cpu_rw_n <= 1'b0;
        next_opcode_addr <= 8'hc5;
        count(2);
        `CHK({muxed_addr_data_port_oe, muxed_addr_data_port_out, address_strobe_n, read_write_n}, 11'h4f0)
        dma_len(1'b0, dr);
        dma_len(1'b1, dm);
        `CHK(dm - dr, 8)
        wfi_req <= 1'b1;
        @(posedge hclk);
        wfi_req <= 1'b0;
        @(posedge hclk); // the cycle in flight still ends with a pulse
        count(10);
        `CHK({cc, ci}, {32'd0, 32'd10})
        `CHK({muxed_addr_data_port_oe, address_strobe_n, read_write_n, high_address_port}, 11'h3c5)
        core_priority_level <= 3'h2;
        dma_priority <= 3'h5;
        dma_req <= 1'b1;
        count(20);
        `CHK(dma_active, 1'b0)
        dma_priority <= 3'h2;
        dma_len(1'b0, dw);
        `CHK(dw - dr, 2)
        count(6);
        `CHK(cc, 0)
        irq_ack <= 1'b1;
        @(posedge hclk);
        irq_ack <= 1'b0;
        count(6);
        `CHK(cc > 3, 1'b1)
    endtask : t_wfi
    task automatic t_halt;
        ahb(1'b1, OFS_WAIT_CTRL, 32'h3f);
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        count(3);
        `CHK({halt_loop, ci > 2}, 2'h3)
        do_reset();
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        count(3);
        count(10);
        `CHK({oscillator_output, ci, cc}, {1'b1, 64'd0})
        do_reset();
        count(4);
        `CHK(ci > 0, 1'b1)
    endtask : t_halt
    initial begin
        do_reset();
        t_regs();
        t_clocks();
        t_waits();
        t_wfi();
        t_halt();
        end_of_test();
    end
endmodule : clock_wait_halt_control_tb_top
`default_nettype wire
